// ===== design/dxo_map.svh
// Purpose: constants for the dmx output slot merge block
// Assumes: 10 MHz clock
// Notes: times in their own units, counts derived from them
`ifndef DXO_MAP_SVH
`define DXO_MAP_SVH
`define DXO_CLK_HZ        10000000
`define DXO_SLOTS         512
`define DXO_UNIV2_BASE    10'h200
`define DXO_MIN_RATE_HZ   44
// longest frame period allowed, rounded down to whole cycles
`define DXO_FRAME_CYC     (`DXO_CLK_HZ / `DXO_MIN_RATE_HZ)
`define DXO_LEVEL_OFF     8'h00
`define DXO_LEVEL_FULL    8'hFF
// crossfade weight that stands for the whole of the incoming scene
`define DXO_FADE_ONE      9'h100
`define DXO_FIFO_DEPTH    32
`endif

// ===== design/dxo_pkg.sv
// Purpose: shared types for the dmx output slot merge block
// Assumes: nothing
// Notes: numbers live in dxo_map.svh
package dxo_pkg;
  typedef logic [7:0] dxo_level_t;
  typedef logic [9:0] dxo_slot_t;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PUSH} dxo_state_e;
endpackage : dxo_pkg

// ===== design/dxo_stream_if.sv
// Purpose: valid/ready slot stream between merge core and fifo
// Assumes: single clock
// Notes: data is {universe, slot index, level}
`timescale 1ns/1ns
`default_nettype none
interface dxo_stream_if #(parameter int W = 18);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dxo_stream_if
`default_nettype wire

// ===== design/dxo_fifo.sv
// Purpose: parameterised fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/1ns
`default_nettype none
module dxo_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // fill and drain sides
  dxo_stream_if.snk inp,
  dxo_stream_if.src outp
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wrPtr;
  logic [AW:0]  rdPtr;
  logic         full;
  logic         empty;
  assign full  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty = (wrPtr == rdPtr);
  assign inp.ready  = !full;
  assign outp.valid = !empty;
  assign outp.data  = mem[rdPtr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (inp.valid && !full) begin
      mem[wrPtr[AW-1:0]] <= inp.data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
    end else if (inp.valid && !full) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rdPtr <= '0;
    end else if (outp.valid && outp.ready) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end
  fifoOrder_a: assert property (@(posedge clk) disable iff (rst)
    full |=> $stable(wrPtr))
    else $error("fifo writes while full");
endmodule : dxo_fifo
`default_nettype wire

// ===== design/dxo_slot_merge.sv
// Purpose: merges level sources and streams two universes of 512 slots
// Assumes: 10 MHz clk, synchronous active-high rst, sources on clk domain
// Notes: break/mark timing and serialising are done downstream of slotValid
`timescale 1ns/1ns
`default_nettype none
`include "dxo_map.svh"
// Summary of operation
// - each universe's slot levels go out one after another from slot 1 up to slot 512.
// - the full slot sequence repeats without end, at least 44 times per second.
// - internal slots 1 to 512 go out as slots 1 to 512 of the first universe.
// - internal slots 513 to 1024 go out as slots 1 to 512 of the second universe.
// - where several sources drive one channel the highest level is sent.
// - in a dipless crossfade a channel lit in both scenes moves straight between its levels.
// - a grab copies every active channel and its level into the grab master.
// - a chase steps through its steps in order and wraps back to the first.
// - a bank master scales every channel fader of its bank together.
module dxo_slot_merge #(
  parameter int SLOTS      = 1024,
  parameter int STEPS      = 8,
  parameter int FRAME_CYC  = `DXO_FRAME_CYC
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // bank faders and master
  input  wire logic [7:0]       bankLevel,
  input  wire logic [7:0]       bankMaster,
  // crossfade: outgoing and incoming scene, fade position
  input  wire logic [7:0]       sceneOut,
  input  wire logic [7:0]       sceneIn,
  input  wire logic [7:0]       fadePos,
  // chase step levels, step advance pulse
  input  wire logic [7:0]       chaseStep [STEPS],
  input  wire logic             chaseAdvance,
  // grab command and grab master fader
  input  wire logic             grabCmd,
  input  wire logic [7:0]       grabMaster,
  // slot index being looked up by the sources
  output logic      [9:0]       lookupSlot,
  // serial stream out
  output logic                  slotValid,
  input  wire logic             slotReady,
  output logic                  slotUniverse,
  output logic      [8:0]       slotNumber,
  output logic      [7:0]       slotLevel,
  output logic                  frameStart
);
  dxo_stream_if #(.W(18)) toFifo ();
  dxo_stream_if #(.W(18)) fromFifo ();

  dxo_pkg::dxo_state_e   state;
  dxo_pkg::dxo_slot_t    scanSlot;
  dxo_pkg::dxo_level_t   merged;
  dxo_pkg::dxo_level_t   grabStore [SLOTS];
  logic [$clog2(STEPS)-1:0] chaseIdx;
  logic [31:0]           frameTimer;
  logic                  frameDue;
  logic                  grabPending;
  logic                  grabCopy;
  logic [15:0]           bankProd;
  logic [15:0]           fadeOutProd;
  logic [15:0]           fadeInProd;
  logic [15:0]           grabProd;
  logic [8:0]            fadeWeight;
  logic [16:0]           xfadeSum;
  dxo_pkg::dxo_level_t   xfade;
  dxo_pkg::dxo_level_t   bankScaled;
  dxo_pkg::dxo_level_t   grabScaled;
  dxo_pkg::dxo_level_t   chaseLevel;

  // level sources
  assign bankProd    = bankLevel * bankMaster;
  assign bankScaled  = bankProd[15:8];
  // weight runs 0..256 so both end points give the scene level exactly
  assign fadeWeight  = {1'b0, fadePos} + {8'h00, fadePos[7]};
  assign fadeOutProd = sceneOut * (`DXO_FADE_ONE - fadeWeight);
  assign fadeInProd  = sceneIn * fadeWeight;
  // linear blend of the two scenes never drops below the lower end point
  assign xfadeSum    = {1'b0, fadeOutProd} + {1'b0, fadeInProd};
  assign xfade       = xfadeSum[16] ? `DXO_LEVEL_FULL : xfadeSum[15:8];
  assign grabProd    = grabStore[scanSlot] * grabMaster;
  assign grabScaled  = grabProd[15:8];
  assign chaseLevel  = chaseStep[chaseIdx];

  always_comb begin
    merged = bankScaled;
    if (xfade > merged) begin
      merged = xfade;
    end
    if (chaseLevel > merged) begin
      merged = chaseLevel;
    end
    if (grabScaled > merged) begin
      merged = grabScaled;
    end
  end

  // chase steps in order and wraps
  always_ff @(posedge clk) begin
    if (rst) begin
      chaseIdx <= '0;
    end else if (chaseAdvance) begin
      chaseIdx <= (chaseIdx == STEPS[$clog2(STEPS)-1:0] - 1'b1) ? '0 : chaseIdx + 1'b1;
    end
  end

  // grab is armed at any time; a command in the start cycle wins and waits for the next scan
  always_ff @(posedge clk) begin
    if (rst) begin
      grabPending <= 1'b0;
    end else if (grabCmd) begin
      grabPending <= 1'b1;
    end else if (state == dxo_pkg::ST_IDLE && frameDue) begin
      grabPending <= 1'b0;
    end
  end

  // copy spans one whole scan, slot 0 to the last, so no slot is missed
  always_ff @(posedge clk) begin
    if (rst) begin
      grabCopy <= 1'b0;
    end else if (state == dxo_pkg::ST_IDLE && frameDue) begin
      grabCopy <= grabPending;
    end else if (state == dxo_pkg::ST_PUSH && toFifo.ready && scanSlot == dxo_pkg::dxo_slot_t'(SLOTS - 1)) begin
      grabCopy <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (grabCopy && state == dxo_pkg::ST_PUSH && toFifo.ready) begin
      grabStore[scanSlot] <= merged;
    end
  end

  // frame timer guarantees the minimum refresh
  always_ff @(posedge clk) begin
    if (rst) begin
      frameTimer <= '0;
      frameDue   <= 1'b1;
    end else if (frameTimer == FRAME_CYC - 1) begin
      frameTimer <= '0;
      frameDue   <= 1'b1;
    end else begin
      frameTimer <= frameTimer + 1;
      if (state == dxo_pkg::ST_IDLE && frameDue) begin
        frameDue <= 1'b0;
      end
    end
  end

  // slot scanner
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= dxo_pkg::ST_IDLE;
      scanSlot <= '0;
    end else begin
      case (state)
        dxo_pkg::ST_IDLE: begin
          if (frameDue) begin
            scanSlot <= '0;
            state    <= dxo_pkg::ST_READ;
          end
        end
        dxo_pkg::ST_READ: state <= dxo_pkg::ST_PUSH;
        dxo_pkg::ST_PUSH: begin
          if (toFifo.ready) begin
            if (scanSlot == dxo_pkg::dxo_slot_t'(SLOTS - 1)) begin
              state <= dxo_pkg::ST_IDLE;
            end else begin
              scanSlot <= scanSlot + 1'b1;
              state    <= dxo_pkg::ST_READ;
            end
          end
        end
        default: state <= dxo_pkg::ST_IDLE;
      endcase
    end
  end

  assign lookupSlot   = scanSlot;
  assign toFifo.valid = (state == dxo_pkg::ST_PUSH);
  // upper half of the internal space becomes universe two, slots renumbered from 1
  assign toFifo.data  = {scanSlot >= `DXO_UNIV2_BASE, scanSlot[8:0], merged};

  dxo_fifo #(.W(18), .DEPTH(`DXO_FIFO_DEPTH)) u_fifo (
    .clk  (clk),
    .rst  (rst),
    .inp  (toFifo),
    .outp (fromFifo)
  );

  // output register stage; fifo pops only when the output slot is free
  assign fromFifo.ready = !slotValid || slotReady;
  always_ff @(posedge clk) begin
    if (rst) begin
      slotValid    <= 1'b0;
      slotUniverse <= 1'b0;
      slotNumber   <= '0;
      slotLevel    <= `DXO_LEVEL_OFF;
      frameStart   <= 1'b0;
    end else if (fromFifo.ready) begin
      slotValid    <= fromFifo.valid;
      slotUniverse <= fromFifo.data[17];
      slotNumber   <= fromFifo.data[16:8];
      slotLevel    <= fromFifo.data[7:0];
      frameStart   <= fromFifo.valid && fromFifo.data[16:8] == '0;
    end
  end

  slotOrder_a: assert property (@(posedge clk) disable iff (rst)
    (state == dxo_pkg::ST_PUSH && toFifo.ready && scanSlot != dxo_pkg::dxo_slot_t'(SLOTS - 1))
      |=> ##1 scanSlot == $past(scanSlot, 2) + 1'b1)
    else $error("slot order broken");
  univSplit_a: assert property (@(posedge clk) disable iff (rst)
    toFifo.valid |-> toFifo.data[17] == scanSlot[9])
    else $error("universe split wrong");
  mergeMax_a: assert property (@(posedge clk) disable iff (rst)
    merged >= bankScaled && merged >= chaseLevel && merged >= xfade)
    else $error("merge not highest");
  noDip_a: assert property (@(posedge clk) disable iff (rst)
    (sceneOut == sceneIn) |-> xfade == sceneIn)
    else $error("crossfade dips");
  chaseWrap_a: assert property (@(posedge clk) disable iff (rst)
    (chaseAdvance && chaseIdx == STEPS - 1) |=> chaseIdx == '0)
    else $error("chase fails to wrap");
  refresh_a: assert property (@(posedge clk) disable iff (rst)
    frameTimer == FRAME_CYC - 1 |=> frameDue)
    else $error("refresh missed");
  bankScale_a: assert property (@(posedge clk) disable iff (rst)
    bankMaster == `DXO_LEVEL_OFF |-> bankScaled == `DXO_LEVEL_OFF)
    else $error("bank master ignored");
  univOne_a: assert property (@(posedge clk) disable iff (rst)
    (toFifo.valid && scanSlot < `DXO_UNIV2_BASE) |-> !toFifo.data[17])
    else $error("universe one wrong");
  frameCv: cover property (@(posedge clk) frameStart);
  grabCv: cover property (@(posedge clk) grabCopy && state == dxo_pkg::ST_PUSH);
  stallCv: cover property (@(posedge clk) toFifo.valid && !toFifo.ready);
endmodule : dxo_slot_merge
`default_nettype wire

// ===== bench/dxo_rx_model.sv
// Purpose: receiver on the slot stream, such as a rack of dimmers
// Assumes: slotNumber 0 carries slot 1
// Notes: ready drops at random while slow is high, and pauses mid-universe long enough to fill the fifo
`timescale 1ns/1ns
`default_nettype none
module dxo_rx_model #(
  parameter int START = 13,
  parameter int N     = 12,
  parameter bit UNIV  = 1'b1
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // slot stream
  input  wire logic       slotValid,
  output logic            slotReady,
  input  wire logic       slotUniverse,
  input  wire logic [8:0] slotNumber,
  input  wire logic [7:0] slotLevel,
  // pacing and decoded outputs
  input  wire logic       slow,
  output logic      [7:0] outLevel [N]
);
  int seed = 32'hA12D;
  int hold = 0;
  always @(posedge clk) begin
    int pos;
    slotReady <= rst ? 1'b0 : (hold == 0 && (!slow || ($random(seed) & 7) != 0));
    // pause away from slot 1 so the frame start is never delayed by it
    if (rst) hold <= 0;
    else if (slow && slotValid && slotReady && slotNumber == 9'h0FF) hold <= 80;
    else if (hold > 0) hold <= hold - 1;
    if (slotValid && slotReady && slotUniverse == UNIV) begin
      // any start address is taken, shared or out of order along the chain
      pos = int'(slotNumber) + 1 - START;
      if (pos >= 0 && pos < N) outLevel[pos] <= slotLevel;
    end
  end
endmodule : dxo_rx_model
`default_nettype wire

// ===== bench/tb.sv
// Purpose: self-checking bench for the slot merge block
// Assumes: inputs held steady over a whole checked frame
// Notes: frames after each change are skipped, the fifo holds stale slots
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int FC = 2400;
  localparam int ST = 4;
  logic       clk = 0, rst = 1, chaseAdvance = 0, grabCmd = 0, slow = 1;
  logic [7:0] bankLevel = 0, bankMaster = 0, sceneOut = 0, sceneIn = 0, fadePos = 0, grabMaster = 0;
  logic [7:0] chaseStep [ST];
  logic       slotValid, slotReady, slotUniverse, frameStart;
  logic [8:0] slotNumber;
  logic [7:0] slotLevel;
  logic [7:0] rxLev [12];
  int num_errors = 0, n_checks = 0, seed = 32'hA12D;
  int frameCnt = 0, target = -1, pos = 0, cyc = 0, lo = 0, hi = 0, chIdx = 0, gStore = 0;
  always #50 clk = ~clk;
  dxo_slot_merge #(.SLOTS(1024), .STEPS(ST), .FRAME_CYC(FC)) uut (.clk(clk), .rst(rst),
    .bankLevel(bankLevel), .bankMaster(bankMaster), .sceneOut(sceneOut), .sceneIn(sceneIn),
    .fadePos(fadePos), .chaseStep(chaseStep), .chaseAdvance(chaseAdvance), .grabCmd(grabCmd),
    .grabMaster(grabMaster), .lookupSlot(), .slotValid(slotValid), .slotReady(slotReady),
    .slotUniverse(slotUniverse), .slotNumber(slotNumber), .slotLevel(slotLevel), .frameStart(frameStart));
  dxo_rx_model #(.START(13), .N(12), .UNIV(1'b1)) rx (.clk(clk), .rst(rst), .slotValid(slotValid),
    .slotReady(slotReady), .slotUniverse(slotUniverse), .slotNumber(slotNumber),
    .slotLevel(slotLevel), .slow(slow), .outLevel(rxLev));
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  function automatic int sc(input int a, input int b);
    return (a * b) >> 8;
  endfunction : sc
  function automatic int mx(input int a, input int b);
    return a > b ? a : b;
  endfunction : mx
  always @(posedge clk) begin
    cyc++;
    if (!rst && slotValid && slotReady) begin
      // frameStart also marks slot 1 of universe two; frames are counted on universe one
      chk(frameStart === (pos[8:0] == 9'h000), "frame start out of place");
      if (frameStart === 1'b1 && slotUniverse === 1'b0) begin
        if (frameCnt > 0) chk(cyc <= FC + 8, "frame period too long");
        frameCnt++;
        pos = 0;
        cyc = 0;
      end
      chk(slotUniverse === pos[9] && slotNumber === pos[8:0], "slot order");
      if (frameCnt == target) chk(slotLevel >= lo && slotLevel <= hi, "slot level");
      pos = (pos + 1) % 1024;
    end
  end
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    n = frameCnt + n;
    while (frameCnt < n && k < 4 * FC) begin
      @(negedge clk);
      k++;
    end
    chk(frameCnt >= n, "frame timeout");
  endtask : wait_frames
  // changes come just after a frame start; that frame in flight may carry slots sampled before it
  task automatic settle(input int l, input int h);
    lo = l;
    hi = h;
    target = frameCnt + 1;
    wait_frames(2);
  endtask : settle
  task automatic exact(input int xf);
    int e;
    e = mx(mx(sc(bankLevel, bankMaster), xf), mx(chaseStep[chIdx], sc(gStore, grabMaster)));
    settle(e, e);
    chk(rxLev[0] === 8'(e) && rxLev[11] === 8'(e), "receiver levels");
  endtask : exact
  task give_verdict;
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #(100 * 90000);
    num_errors++;
    give_verdict;
  end
  initial begin
    for (int i = 0; i < ST; i++) chaseStep[i] = 8'h00;
    repeat (12) @(negedge clk);
    rst = 0;
    exact(0);
    for (int r = 0; r < 3; r++) begin
      slow = r[0];
      bankLevel = $random(seed);
      bankMaster = $random(seed);
      sceneOut = $random(seed);
      chaseStep[0] = $random(seed);
      exact(sceneOut);
    end
    bankLevel = 8'hFF;
    bankMaster = 8'hFF;
    sceneOut = 8'h00;
    chaseStep[0] = 8'h00;
    exact(0);
    bankLevel = 8'h00;
    sceneOut = 8'hFF;
    exact(255);
    sceneOut = 8'h80;
    sceneIn = 8'h80;
    fadePos = 8'h40;
    settle(8'h80, 8'h80);
    sceneIn = 8'hC0;
    fadePos = 8'h80;
    settle(8'h80, 8'hC0);
    fadePos = 8'hFF;
    exact(8'hC0);
    grabCmd = 1;
    @(negedge clk);
    grabCmd = 0;
    gStore = 8'hC0;
    wait_frames(3);
    sceneIn = 8'h00;
    grabMaster = 8'hFF;
    exact(0);
    grabMaster = 8'h00;
    for (int i = 0; i < ST; i++) chaseStep[i] = 8'(16 * (i + 1));
    for (int i = 0; i <= ST; i++) begin
      exact(0);
      chaseAdvance = 1;
      @(negedge clk);
      chaseAdvance = 0;
      chIdx = (chIdx + 1) % ST;
    end
    give_verdict;
  end
endmodule : tb
`default_nettype wire
